//--- src/adc_error_threshold_compare.sv
// Top of the threshold-compare stage with its byte register file
//
// What this block does
// - Calculation error readable as two read-only bytes, high and low.
// - Calculation error formed as the calculation mode field selects.
// - Error compared with both thresholds; sets above and below status flags.
// - Threshold interrupt raised only when the interrupt mode selects the outcome.
// - Lower threshold writable as high and low bytes.
// - Upper threshold writable as high and low bytes.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/10ps
module adc_error_threshold_compare
  import thr_cmp_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Register port
  input wire thr_cmp_pkg::reg_req_s i_reg,
  output logic [7:0] o_rdata,
  // Conversion results from the converter
  input wire thr_cmp_pkg::calc_in_s i_calc,
  // Results
  output logic o_threshold_int,
  output logic o_above_upper_flag,
  output logic o_below_lower_flag,
  output logic o_calc_done
);

  logic [WIDTH-1:0] lower_threshold_q;
  logic [WIDTH-1:0] upper_threshold_q;
  logic [WIDTH-1:0] setpoint_q;
  logic [2:0] calc_mode_select_q;
  logic [2:0] threshold_int_mode_q;
  logic [WIDTH-1:0] calc_error_value;
  logic above_upper_flag;
  logic below_lower_flag;
  logic hit;
  logic done;
  logic [7:0] rdata_d;
  logic [7:0] status_byte;
  logic [7:0] control_byte;

  // ---------------------------------------------------------------
  // Threshold registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      lower_threshold_q <= WIDTH'(RST_WORD);
      upper_threshold_q <= WIDTH'(RST_WORD);
    end
    else if (i_reg.wr)
    begin
      case (i_reg.addr)
        OFS_LOWER_THRESHOLD_HIGH: lower_threshold_q[15:8] <= i_reg.wdata;
        OFS_LOWER_THRESHOLD_LOW: lower_threshold_q[7:0] <= i_reg.wdata;
        OFS_UPPER_THRESHOLD_HIGH: upper_threshold_q[15:8] <= i_reg.wdata;
        OFS_UPPER_THRESHOLD_LOW: upper_threshold_q[7:0] <= i_reg.wdata;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Control and setpoint registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      calc_mode_select_q <= RST_BYTE[2:0];
      threshold_int_mode_q <= RST_BYTE[2:0];
      setpoint_q <= WIDTH'(RST_WORD);
    end
    else if (i_reg.wr)
    begin
      case (i_reg.addr)
        OFS_CONVERTER_CONTROL_THIRD:
        begin
          calc_mode_select_q <= i_reg.wdata[CALC_MODE_LSB +: 3];
          threshold_int_mode_q <= i_reg.wdata[THR_MODE_LSB +: 3];
        end
        OFS_SETPOINT_HIGH: setpoint_q[15:8] <= i_reg.wdata;
        OFS_SETPOINT_LOW: setpoint_q[7:0] <= i_reg.wdata;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Datapath
  // ---------------------------------------------------------------
  thr_compare_core #(
    .WIDTH(WIDTH)
  ) u_core (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_calc(i_calc),
    .i_calc_mode(calc_mode_select_q),
    .i_setpoint(setpoint_q),
    .i_lower(lower_threshold_q),
    .i_upper(upper_threshold_q),
    .i_tmd(threshold_int_mode_q),
    .o_error(calc_error_value),
    .o_above(above_upper_flag),
    .o_below(below_lower_flag),
    .o_int(hit),
    .o_done(done)
  );

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[ABOVE_UPPER_BIT] = above_upper_flag;
    status_byte[BELOW_LOWER_BIT] = below_lower_flag;
    control_byte = 8'h00;
    control_byte[CALC_MODE_LSB +: 3] = calc_mode_select_q;
    control_byte[THR_MODE_LSB +: 3] = threshold_int_mode_q;
    case (i_reg.addr)
      OFS_CALC_ERROR_HIGH: rdata_d = calc_error_value[15:8];
      OFS_CALC_ERROR_LOW: rdata_d = calc_error_value[7:0];
      OFS_LOWER_THRESHOLD_HIGH: rdata_d = lower_threshold_q[15:8];
      OFS_LOWER_THRESHOLD_LOW: rdata_d = lower_threshold_q[7:0];
      OFS_UPPER_THRESHOLD_HIGH: rdata_d = upper_threshold_q[15:8];
      OFS_UPPER_THRESHOLD_LOW: rdata_d = upper_threshold_q[7:0];
      OFS_CONVERTER_CONTROL_THIRD: rdata_d = control_byte;
      OFS_CONVERTER_STATUS_REG: rdata_d = status_byte;
      OFS_SETPOINT_HIGH: rdata_d = setpoint_q[15:8];
      OFS_SETPOINT_LOW: rdata_d = setpoint_q[7:0];
      default: rdata_d = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      o_rdata <= RST_BYTE;
    end
    else if (i_reg.rd)
    begin
      o_rdata <= rdata_d;
    end
    else
    begin
      o_rdata <= RST_BYTE;
    end
  end

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      o_threshold_int <= 1'b0;
      o_above_upper_flag <= 1'b0;
      o_below_lower_flag <= 1'b0;
      o_calc_done <= 1'b0;
    end
    else
    begin
      o_threshold_int <= hit;
      o_above_upper_flag <= above_upper_flag;
      o_below_lower_flag <= below_lower_flag;
      o_calc_done <= done;
    end
  end

endmodule // adc_error_threshold_compare

//--- src/thr_cmp_pkg.sv
// Package: register map, field layouts and encodings of the threshold-compare stage
package thr_cmp_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte-wide registers on the plain port)
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_CALC_ERROR_HIGH = 4'h0;
  localparam logic [3:0] OFS_CALC_ERROR_LOW = 4'h1;
  localparam logic [3:0] OFS_LOWER_THRESHOLD_HIGH = 4'h2;
  localparam logic [3:0] OFS_LOWER_THRESHOLD_LOW = 4'h3;
  localparam logic [3:0] OFS_UPPER_THRESHOLD_HIGH = 4'h4;
  localparam logic [3:0] OFS_UPPER_THRESHOLD_LOW = 4'h5;
  localparam logic [3:0] OFS_CONVERTER_CONTROL_THIRD = 4'h6;
  localparam logic [3:0] OFS_CONVERTER_STATUS_REG = 4'h7;
  localparam logic [3:0] OFS_SETPOINT_HIGH = 4'h8;
  localparam logic [3:0] OFS_SETPOINT_LOW = 4'h9;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CALC_MODE_LSB = 4;
  localparam int THR_MODE_LSB = 0;
  localparam int ABOVE_UPPER_BIT = 6;
  localparam int BELOW_LOWER_BIT = 5;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ---------------------------------------------------------------
  // Calculation modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CALC_SAMPLE_MINUS_PREV = 3'h0,
    CALC_SAMPLE_MINUS_SETPOINT = 3'h1,
    CALC_FILTER_MINUS_SETPOINT = 3'h2,
    CALC_FILTER_MINUS_PREV = 3'h3,
    CALC_SAMPLE_RAW = 3'h4
  } calc_mode_e;

  // ---------------------------------------------------------------
  // Threshold interrupt modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    TMD_NEVER = 3'h0,
    TMD_BELOW_LOWER = 3'h1,
    TMD_ABOVE_UPPER = 3'h2,
    TMD_INSIDE = 3'h3,
    TMD_OUTSIDE = 3'h4,
    TMD_NOT_BELOW_LOWER = 3'h5,
    TMD_NOT_ABOVE_UPPER = 3'h6,
    TMD_ALWAYS = 3'h7
  } thr_int_mode_e;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic valid;
    logic [15:0] sample;
    logic [15:0] filtered;
    logic [15:0] previous;
  } calc_in_s;

endpackage

//--- src/thr_compare_core.sv
// Calculation error and threshold comparison datapath
`timescale 1ns/10ps
module thr_compare_core
  import thr_cmp_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Operands
  input wire thr_cmp_pkg::calc_in_s i_calc,
  input wire logic [2:0] i_calc_mode,
  input wire logic [WIDTH-1:0] i_setpoint,
  input wire logic [WIDTH-1:0] i_lower,
  input wire logic [WIDTH-1:0] i_upper,
  input wire logic [2:0] i_tmd,
  // Results
  output logic [WIDTH-1:0] o_error,
  output logic o_above,
  output logic o_below,
  output logic o_int,
  output logic o_done
);

  logic [WIDTH-1:0] error_d;
  logic [WIDTH-1:0] error_q;
  logic above_d;
  logic below_d;
  logic hit_d;

  // ---------------------------------------------------------------
  // Error selection
  // ---------------------------------------------------------------
  always_comb
  begin
    case (calc_mode_e'(i_calc_mode))
      CALC_SAMPLE_MINUS_PREV: error_d = i_calc.sample - i_calc.previous;
      CALC_SAMPLE_MINUS_SETPOINT: error_d = i_calc.sample - i_setpoint;
      CALC_FILTER_MINUS_SETPOINT: error_d = i_calc.filtered - i_setpoint;
      CALC_FILTER_MINUS_PREV: error_d = i_calc.filtered - i_calc.previous;
      CALC_SAMPLE_RAW: error_d = i_calc.sample;
      default: error_d = i_calc.sample;
    endcase
  end

  // ---------------------------------------------------------------
  // Signed compare and interrupt selection
  // ---------------------------------------------------------------
  always_comb
  begin
    above_d = $signed(error_d) > $signed(i_upper);
    below_d = $signed(error_d) < $signed(i_lower);
    case (thr_int_mode_e'(i_tmd))
      TMD_NEVER: hit_d = 1'b0;
      TMD_BELOW_LOWER: hit_d = below_d;
      TMD_ABOVE_UPPER: hit_d = above_d;
      TMD_INSIDE: hit_d = !below_d && !above_d;
      TMD_OUTSIDE: hit_d = below_d || above_d;
      TMD_NOT_BELOW_LOWER: hit_d = !below_d;
      TMD_NOT_ABOVE_UPPER: hit_d = !above_d;
      TMD_ALWAYS: hit_d = 1'b1;
      default: hit_d = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Result registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      error_q <= WIDTH'(RST_WORD);
      o_above <= 1'b0;
      o_below <= 1'b0;
    end
    else if (i_calc.valid)
    begin
      error_q <= error_d;
      o_above <= above_d;
      o_below <= below_d;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      o_int <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_int <= i_calc.valid && hit_d;
      o_done <= i_calc.valid;
    end
  end

  assign o_error = error_q;

endmodule // thr_compare_core

//--- dv/adc_error_threshold_compare_assertions.sv
// Port checker for the threshold-compare stage
`timescale 1ns/10ps
module thr_cmp_chk
  import thr_cmp_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Register port
  input wire thr_cmp_pkg::reg_req_s i_reg,
  input wire logic [7:0] o_rdata,
  // Results
  input wire thr_cmp_pkg::calc_in_s i_calc,
  input wire logic o_threshold_int,
  input wire logic o_above_upper_flag,
  input wire logic o_below_lower_flag,
  input wire logic o_calc_done
);
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);
  logic [2:0] tmd_q;
  logic [3:0] wa_q;
  logic [7:0] wd_q;
  logic wv_q;
  logic [7:0] hit;
  logic a;
  logic b;
  logic rd_st;
  logic rd_thr;
  assign a = o_above_upper_flag;
  assign b = o_below_lower_flag;
  assign hit = {1'b1, !a, !b, a | b, !a & !b, a, b, 1'b0};
  assign rd_st = i_reg.rd && i_reg.addr == OFS_CONVERTER_STATUS_REG;
  assign rd_thr = i_reg.rd && wv_q && i_reg.addr == wa_q;
  // Interrupt mode as last written
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      tmd_q <= 3'h0;
    else if (i_reg.wr && i_reg.addr == OFS_CONVERTER_CONTROL_THIRD)
      tmd_q <= i_reg.wdata[2:0];
  end
  // Last threshold byte written
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      wv_q <= 1'b0;
    else if (i_reg.wr && i_reg.addr inside {[4'h2:4'h5]})
    begin
      wv_q <= 1'b1;
      wa_q <= i_reg.addr;
      wd_q <= i_reg.wdata;
    end
  end
  chk_done_timing: assert property (o_calc_done ==
    ($past(i_calc.valid, 2) && $past(i_resetn, 2) && $past(i_resetn)))
    else $error("done not two cycles after valid");
  chk_int_with_done: assert property (o_threshold_int |-> o_calc_done)
    else $error("interrupt without new result");
  chk_int_by_mode: assert property (o_calc_done |-> o_threshold_int == hit[$past(tmd_q, 2)])
    else $error("interrupt disagrees with mode");
  chk_flags_hold: assert property (!o_calc_done && $past(i_resetn) |-> $stable(a) && $stable(b))
    else $error("flags moved without new result");
  chk_rdata_idle: assert property (!$past(i_reg.rd) |-> o_rdata == 8'h00)
    else $error("read data outside read cycle");
  chk_status_read: assert property ($past(rd_st) |-> o_rdata == {1'b0, a, b, 5'h00})
    else $error("status read disagrees with flags");
  chk_thr_readback: assert property ($past(rd_thr) && $past(i_resetn) |-> o_rdata == $past(wd_q))
    else $error("threshold byte not as written");
endmodule // thr_cmp_chk

bind adc_error_threshold_compare thr_cmp_chk u_chk (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_reg(i_reg), .o_rdata(o_rdata),
  .i_calc(i_calc), .o_threshold_int(o_threshold_int),
  .o_above_upper_flag(o_above_upper_flag), .o_below_lower_flag(o_below_lower_flag),
  .o_calc_done(o_calc_done));

//--- dv/test_adc_error_threshold_compare.sv
// Self-checking bench for the threshold-compare stage
`timescale 1ns/10ps
module test_adc_error_threshold_compare;
  import thr_cmp_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  reg_req_s rq = '0;
  calc_in_s cv = '0;
  logic [7:0] rdata;
  logic t_int, a_f, b_f, done;
  logic [15:0] lo_t = 16'hFFF6;
  logic [15:0] up_t = 16'h0064;
  logic [2:0] tm = 3'h0;
  int fails = 0;
  int n_checks = 0;
  always #10 i_clk_sys = ~i_clk_sys;
  adc_error_threshold_compare dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_reg(rq),
    .o_rdata(rdata), .i_calc(cv), .o_threshold_int(t_int), .o_above_upper_flag(a_f),
    .o_below_lower_flag(b_f), .o_calc_done(done));
  task automatic conclude();
    if (fails == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [3:0] ad, logic [7:0] d);
    @(posedge i_clk_sys);
    rq <= '{ad, d, 1'b1, 1'b0};
    @(posedge i_clk_sys);
    rq <= '0;
  endtask
  task automatic rd(logic [3:0] ad, logic [7:0] e);
    @(posedge i_clk_sys);
    rq <= '{ad, 8'h00, 1'b0, 1'b1};
    @(posedge i_clk_sys);
    rq <= '0;
    #1 chk(rdata, e);
  endtask
  task automatic wr16(logic [3:0] ad, logic [15:0] v);
    wr(ad, v[15:8]);
    wr(ad + 4'h1, v[7:0]);
  endtask
  task automatic ctl(logic [2:0] m, logic [2:0] t);
    tm = t;
    wr(OFS_CONVERTER_CONTROL_THIRD, {1'b0, m, 1'b0, t});
  endtask
  // One new result, then pins and readback
  task automatic run(logic [15:0] s, logic [15:0] f, logic [15:0] p, logic [15:0] e);
    logic ea;
    logic eb;
    logic [7:0] hv;
    ea = $signed(e) > $signed(up_t);
    eb = $signed(e) < $signed(lo_t);
    hv = {1'b1, !ea, !eb, ea | eb, !ea & !eb, ea, eb, 1'b0};
    @(posedge i_clk_sys);
    cv <= '{valid: 1'b1, sample: s, filtered: f, previous: p};
    @(posedge i_clk_sys);
    cv.valid <= 1'b0;
    @(posedge i_clk_sys);
    #1 chk({4'h0, a_f, b_f, t_int, done}, {4'h0, ea, eb, hv[tm], 1'b1});
    rd(OFS_CALC_ERROR_HIGH, e[15:8]);
    rd(OFS_CALC_ERROR_LOW, e[7:0]);
    rd(OFS_CONVERTER_STATUS_REG, {1'b0, ea, eb, 5'h00});
  endtask
  task automatic s_reset();
    for (int i = 0; i < 11; i++)
      rd(4'(i), 8'h00);
  endtask
  task automatic s_regs();
    wr16(OFS_LOWER_THRESHOLD_HIGH, lo_t);
    wr16(OFS_UPPER_THRESHOLD_HIGH, up_t);
    wr16(OFS_SETPOINT_HIGH, 16'h0010);
    rd(OFS_LOWER_THRESHOLD_HIGH, lo_t[15:8]);
    rd(OFS_LOWER_THRESHOLD_LOW, lo_t[7:0]);
    rd(OFS_UPPER_THRESHOLD_HIGH, up_t[15:8]);
    rd(OFS_UPPER_THRESHOLD_LOW, up_t[7:0]);
    wr(OFS_CALC_ERROR_HIGH, 8'hA5);
    wr(OFS_CALC_ERROR_LOW, 8'h5A);
    wr(4'hF, 8'hFF);
    rd(OFS_CALC_ERROR_HIGH, 8'h00);
    rd(OFS_CALC_ERROR_LOW, 8'h00);
    rd(4'hF, 8'h00);
  endtask
  task automatic s_modes();
    logic [15:0] ev [8] = '{16'h0010, 16'h0110, 16'h00F0, 16'hFFF0,
      16'h0120, 16'h0120, 16'h0120, 16'h0120};
    for (int m = 0; m < 8; m++)
    begin
      ctl(3'(m), 3'h7);
      run(16'h0120, 16'h0100, 16'h0110, ev[m]);
    end
  endtask
  task automatic s_int();
    logic [15:0] sv [4] = '{16'h0064, 16'h0065, 16'hFFF6, 16'hFFF5};
    for (int t = 0; t < 8; t++)
    begin
      ctl(3'h4, 3'(t));
      for (int k = 0; k < 4; k++)
        run(sv[k], 16'h0000, 16'h0000, sv[k]);
    end
  endtask
  initial
  begin
    repeat (12) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    s_reset();
    s_regs();
    s_modes();
    s_int();
    conclude();
  end
  initial
  begin
    repeat (20000) @(posedge i_clk_sys);
    fails++;
    conclude();
  end
endmodule // test_adc_error_threshold_compare
